// File: bbsp_defs.svh
// timing figures, cycle counts and widths for the battery-backed sram port host
`ifndef BBSP_DEFS_SVH
`define BBSP_DEFS_SVH

`define BBSP_ADDR_W 11
`define BBSP_DATA_W 8
`define BBSP_CLK_NS 10

// write cycle figures, ns, fastest grade
`define BBSP_T_WC_NS 150
`define BBSP_T_WEW_NS 90
`define BBSP_T_AW_NS 120
`define BBSP_T_WR_NS 10
// read cycle figures, ns
`define BBSP_T_RC_NS 150
`define BBSP_T_AA_NS 150
`define BBSP_T_OEZ_NS 35
// power-up recovery delay, ms
`define BBSP_T_REC_MS 2

// least times round up to whole cycles
`define BBSP_CEIL(ns) (((ns) + `BBSP_CLK_NS - 1) / `BBSP_CLK_NS)
`define BBSP_WC_CYC `BBSP_CEIL(`BBSP_T_WC_NS)
`define BBSP_WEW_CYC `BBSP_CEIL(`BBSP_T_WEW_NS)
`define BBSP_AW_CYC `BBSP_CEIL(`BBSP_T_AW_NS)
`define BBSP_WR_CYC `BBSP_CEIL(`BBSP_T_WR_NS)
`define BBSP_RC_CYC `BBSP_CEIL(`BBSP_T_RC_NS)
`define BBSP_AA_CYC `BBSP_CEIL(`BBSP_T_AA_NS)
`define BBSP_OEZ_CYC `BBSP_CEIL(`BBSP_T_OEZ_NS)
`define BBSP_REC_CYC ((`BBSP_T_REC_MS * 1000000) / `BBSP_CLK_NS)

// flops between a pin and the logic that reads it
`define BBSP_SYNC_CYC 2
`define BBSP_CNT_W 8
`define BBSP_REC_W 18

`endif

// File: bbsp_pkg.sv
// types shared by the sram port host
package bbsp_pkg;
    typedef enum logic [2:0] {
        ST_POWER,
        ST_IDLE,
        ST_WRITE,
        ST_WREND,
        ST_READ,
        ST_TURN
    } bbsp_state_t;
endpackage

// File: bbsp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module bbsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stageOne_q;
    logic [WIDTH-1:0] stageTwo_q;

    // first stage feeds only the second stage
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    stageOne_q[gi] <= 1'b0;
                    stageTwo_q[gi] <= 1'b0;
                end else begin
                    stageOne_q[gi] <= pinIn[gi];
                    stageTwo_q[gi] <= stageOne_q[gi];
                end
            end
        end
    endgenerate

    assign syncOut = stageTwo_q;
endmodule
`default_nettype wire

// File: bbsp_host.sv
// host controller driving a battery-backed 2k x 8 static ram over its pins
`include "bbsp_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module bbsp_host
    import bbsp_pkg::*;
#(
    parameter int RECOVERY_CYC = `BBSP_REC_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [`BBSP_ADDR_W-1:0] reqAddr,
    input wire logic [`BBSP_DATA_W-1:0] reqData,
    output logic reqReady,
    output logic respValid,
    output logic [`BBSP_DATA_W-1:0] respData,
    input wire logic powerOk,
    output logic sramChipSelN,
    output logic sramWriteN,
    output logic sramOutEnN,
    output logic [`BBSP_ADDR_W-1:0] sramAddr,
    input wire logic [`BBSP_DATA_W-1:0] dqIn,
    output logic [`BBSP_DATA_W-1:0] dqOut,
    output logic dqOe
);
    localparam logic [`BBSP_CNT_W-1:0] WLOW_LAST = `BBSP_CNT_W'(`BBSP_AW_CYC - 1);
    localparam logic [`BBSP_CNT_W-1:0] WREC_LAST = `BBSP_CNT_W'(`BBSP_WC_CYC - `BBSP_AW_CYC - 1);
    localparam logic [`BBSP_CNT_W-1:0] RD_LAST = `BBSP_CNT_W'(`BBSP_AA_CYC + `BBSP_SYNC_CYC - 1);
    localparam logic [`BBSP_CNT_W-1:0] TURN_LAST = `BBSP_CNT_W'(`BBSP_OEZ_CYC - 1);
    localparam logic [`BBSP_REC_W-1:0] REC_LAST = `BBSP_REC_W'(RECOVERY_CYC - 1);

    logic powerSync;
    logic [`BBSP_DATA_W-1:0] dqSync;
    bbsp_state_t state_q, state_d;
    logic [`BBSP_CNT_W-1:0] cnt_q, cnt_d;
    logic [`BBSP_REC_W-1:0] rec_q, rec_d;
    logic cs_q, cs_d, we_q, we_d, oe_q, oe_d, doe_q, doe_d;
    logic ready_q, ready_d, resp_q, resp_d;
    logic [`BBSP_ADDR_W-1:0] addr_q, addr_d;
    logic [`BBSP_DATA_W-1:0] dout_q, dout_d, rdata_q, rdata_d;

    // pins from the memory and the supply monitor cross in through two flops
    bbsp_sync #(.WIDTH(1)) u_pwr_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pinIn(powerOk),
        .syncOut(powerSync)
    );
    bbsp_sync #(.WIDTH(`BBSP_DATA_W)) u_dq_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pinIn(dqIn),
        .syncOut(dqSync)
    );

    // next-state logic for sequencing the strobes
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 1'b1;
        rec_d = rec_q;
        cs_d = cs_q;
        we_d = we_q;
        oe_d = oe_q;
        doe_d = doe_q;
        ready_d = 1'b0;
        resp_d = 1'b0;
        addr_d = addr_q;
        dout_d = dout_q;
        rdata_d = rdata_q;
        if (!powerSync) begin
            // supply gone: deselect, float, restart recovery count
            state_d = ST_POWER;
            cs_d = 1'b1;
            we_d = 1'b1;
            oe_d = 1'b1;
            doe_d = 1'b0;
            rec_d = '0;
        end else begin
            unique case (state_q)
                ST_POWER: begin
                    // strobes stay high until the recovery delay is over
                    rec_d = rec_q + 1'b1;
                    if (rec_q == REC_LAST) begin
                        state_d = ST_IDLE;
                        ready_d = 1'b1;
                    end
                end
                ST_IDLE: begin
                    ready_d = ready_q;
                    if (reqValid && ready_q) begin
                        ready_d = 1'b0;
                        cnt_d = '0;
                        addr_d = reqAddr;
                        cs_d = 1'b0;
                        if (reqWrite) begin
                            // output-drive held high so the bus is ours
                            we_d = 1'b0;
                            dout_d = reqData;
                            doe_d = 1'b1;
                            state_d = ST_WRITE;
                        end else begin
                            oe_d = 1'b0;
                            state_d = ST_READ;
                        end
                    end
                end
                ST_WRITE: begin
                    // address-to-end is the longest low figure, so it sets the pulse
                    if (cnt_q == WLOW_LAST) begin
                        cs_d = 1'b1;
                        we_d = 1'b1;
                        cnt_d = '0;
                        state_d = ST_WREND;
                    end
                end
                ST_WREND: begin
                    // data and address held past the rising strobe
                    doe_d = 1'b0;
                    if (cnt_q == WREC_LAST) begin
                        state_d = ST_IDLE;
                        ready_d = 1'b1;
                    end
                end
                ST_READ: begin
                    // wait access time plus synchroniser delay before sampling
                    if (cnt_q == RD_LAST) begin
                        rdata_d = dqSync;
                        resp_d = 1'b1;
                        cs_d = 1'b1;
                        oe_d = 1'b1;
                        cnt_d = '0;
                        state_d = ST_TURN;
                    end
                end
                ST_TURN: begin
                    // memory may still drive the bus until its float time passes
                    if (cnt_q == TURN_LAST) begin
                        state_d = ST_IDLE;
                        ready_d = 1'b1;
                    end
                end
            endcase
        end
    end

    // registers; every pin output comes straight from here
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= ST_POWER;
            cnt_q <= '0;
            rec_q <= '0;
            cs_q <= 1'b1;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            doe_q <= 1'b0;
            ready_q <= 1'b0;
            resp_q <= 1'b0;
            addr_q <= '0;
            dout_q <= '0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rec_q <= rec_d;
            cs_q <= cs_d;
            we_q <= we_d;
            oe_q <= oe_d;
            doe_q <= doe_d;
            ready_q <= ready_d;
            resp_q <= resp_d;
            addr_q <= addr_d;
            dout_q <= dout_d;
            rdata_q <= rdata_d;
        end
    end

    assign sramChipSelN = cs_q;
    assign sramWriteN = we_q;
    assign sramOutEnN = oe_q;
    assign sramAddr = addr_q;
    assign dqOut = dout_q;
    assign dqOe = doe_q;
    assign reqReady = ready_q;
    assign respValid = resp_q;
    assign respData = rdata_q;

    // helper counters: cycles with write strobe low, chip select low, power good
    logic [`BBSP_CNT_W-1:0] weLowCnt_q, csLowCnt_q;
    logic [`BBSP_REC_W-1:0] pwrGoodCnt_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            weLowCnt_q <= '0;
            csLowCnt_q <= '0;
            pwrGoodCnt_q <= '0;
        end else begin
            weLowCnt_q <= we_q ? '0 : weLowCnt_q + 1'b1;
            csLowCnt_q <= cs_q ? '0 : csLowCnt_q + 1'b1;
            pwrGoodCnt_q <= !powerSync ? '0 : (&pwrGoodCnt_q ? pwrGoodCnt_q : pwrGoodCnt_q + 1'b1);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_addr_stable_write: assert property (!we_q && $past(!we_q) |-> $stable(addr_q))
        else $error("address moved during write");
    a_write_recovery: assert property ($rose(we_q) |-> cs_q ##1 cs_q)
        else $error("strobes not high for recovery");
    a_no_bus_fight: assert property (doe_q |-> oe_q)
        else $error("driving bus while output-drive low");
    a_turnaround_gap: assert property ($rose(oe_q) |-> !doe_q [*4])
        else $error("bus driven inside float window");
    // a power cut may end a write early, so these stand down while the supply is gone;
    // the low counters still hold the full count in the cycle the strobe is seen high
    a_write_pulse_width: assert property (disable iff (reset || !powerSync)
        $rose(we_q) |-> weLowCnt_q >= 8'd9 && weLowCnt_q == 8'd12)
        else $error("write strobe pulse wrong length");
    a_addr_to_end: assert property (disable iff (reset || !powerSync)
        $rose(we_q) |-> csLowCnt_q >= 8'd12)
        else $error("address not valid long enough before write end");
    a_write_cycle_len: assert property (disable iff (reset || !powerSync)
        $fell(we_q) |-> !we_q [*8] ##1 !we_q [*4] ##1 we_q [*3])
        else $error("write cycle shorter than 150 ns");
    a_read_access: assert property ($rose(resp_q) |-> $past(csLowCnt_q) >= 8'd15 && $past(!oe_q))
        else $error("read sampled before access time");
    a_power_deselect: assert property (!powerSync |=> cs_q && we_q && !doe_q)
        else $error("strobes active while power low");
    a_recovery_delay: assert property ($fell(cs_q) |-> pwrGoodCnt_q >= 18'(RECOVERY_CYC))
        else $error("access before recovery delay");
endmodule
`default_nettype wire

// File: bbsp_sram_model.sv
// behavioural model of the battery-backed 2k x 8 static ram
`timescale 1ns/1ns
`default_nettype none
module bbsp_sram_model #(
    parameter int REC_NS = 150
) (
    input wire logic csN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic [10:0] addr,
    input wire logic [7:0] hostData,
    input wire logic hostOe,
    input wire logic powerOk,
    input wire logic batWeak,
    output logic [7:0] bus,
    output logic devOn,
    output logic batLow
);
    logic [7:0] mem [0:2047];
    logic [7:0] floatPat = 8'h5a;
    logic ready = 1'b0;
    wire logic late;
    wire logic wrAct = ready && !csN && !weN;
    // released lines keep changing, so a stale byte never passes for data
    always #10 floatPat = ~floatPat;
    // known contents so untouched bytes can be checked
    initial begin
        batLow = 1'b0;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
        end
    end
    // supply monitor: deselect at once, serve again only after recovery
    always @(powerOk) begin
        if (!powerOk) begin
            ready = 1'b0;
        end else begin
            batLow = batWeak;
            #REC_NS ready = powerOk;
        end
    end
    // write strobe floats outputs at once, well inside 50 ns
    assign devOn = ready && !csN && weN && !oeN;
    assign #(75, 0) late = devOn;
    assign bus = hostOe ? hostData : (late ? mem[addr] : floatPat);
    // latch at end of write; a power cut aborts and touches nothing
    always @(negedge wrAct) begin
        if (ready) begin
            if (batLow) batLow = 1'b0;
            else mem[addr] = bus;
        end
    end
endmodule
`default_nettype wire

// File: bbsp_host_tb.sv
// self-checking bench for the sram port host
`include "bbsp_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module bbsp_host_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [`BBSP_ADDR_W-1:0] reqAddr = '0;
    logic [`BBSP_DATA_W-1:0] reqData = '0;
    logic powerOk = 1'b0;
    logic batWeak = 1'b0;
    logic reqReady, respValid, sramChipSelN, sramWriteN, sramOutEnN, dqOe, devOn, batLow;
    logic [`BBSP_DATA_W-1:0] respData, dqIn, dqOut, q;
    logic [`BBSP_ADDR_W-1:0] sramAddr;
    int errors = 0;
    int checks_done = 0;
    int lat;
    time wrStart = 0, lastEnd = 0, addrT = 0, csFall = 0;
    wire logic hostWr = !sramChipSelN && !sramWriteN;
    always #5 ref_clk = ~ref_clk;
    bbsp_host #(.RECOVERY_CYC(20)) dut_u (.ref_clk(ref_clk), .reset(reset), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
        .respValid(respValid), .respData(respData), .powerOk(powerOk), .sramChipSelN(sramChipSelN),
        .sramWriteN(sramWriteN), .sramOutEnN(sramOutEnN), .sramAddr(sramAddr), .dqIn(dqIn),
        .dqOut(dqOut), .dqOe(dqOe));
    bbsp_sram_model mem_u (.csN(sramChipSelN), .weN(sramWriteN), .oeN(sramOutEnN), .addr(sramAddr),
        .hostData(dqOut), .hostOe(dqOe), .powerOk(powerOk), .batWeak(batWeak), .bus(dqIn),
        .devOn(devOn), .batLow(batLow));
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        checks_done++;
        if (seen !== expv) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic guard(input bit hung);
        if (hung) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (reqReady !== 1'b1) begin
            step();
            n++;
            guard(n > 100);
        end
    endtask
    // one request; lat counts cycles from the take to ready or response
    task automatic do_req(input logic wr, input logic [10:0] a, input logic [7:0] d);
        wait_ready();
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqData = d;
        step();
        reqValid = 1'b0;
        lat = 1;
        while ((wr ? reqReady : respValid) !== 1'b1) begin
            step();
            lat++;
            guard(lat > 60);
        end
        q = respData;
    endtask
    // host timing watched on the pins; a power cut may cut a write short
    always @(negedge sramChipSelN) begin
        chk($time - lastEnd >= 10, 1);
        chk($time - csFall >= 150, 1);
        csFall = $time;
    end
    always @(sramAddr) addrT = $time;
    always @(posedge hostWr) wrStart = $time;
    always @(negedge hostWr) begin
        if (powerOk) begin
            chk($time - wrStart >= 90, 1);
            chk($time - addrT >= 120, 1);
            chk(addrT <= wrStart, 1);
        end
        lastEnd = $time;
    end
    always @(negedge ref_clk) chk(dqOe && devOn, 0);
    task automatic t_reset();
        step();
        chk({sramChipSelN, sramWriteN, sramOutEnN, dqOe, reqReady, respValid}, 6'b111000);
        repeat (5) step();
        chk({sramChipSelN, sramWriteN, reqReady}, 3'b110);
        powerOk = 1'b1;
        lat = 0;
        while (reqReady !== 1'b1) begin
            chk(sramChipSelN & sramWriteN, 1);
            step();
            lat++;
            guard(lat > 60);
        end
        chk(lat >= 20, 1);
        $display("test reset done");
    endtask
    task automatic t_rw();
        logic [10:0] a [4] = '{11'h000, 11'h7ff, 11'h2aa, 11'h555};
        logic [7:0] d [4] = '{8'hc3, 8'hff, 8'h00, 8'h96};
        for (int i = 0; i < 4; i++) begin
            do_req(1'b1, a[i], d[i]);
            chk(lat, 16);
        end
        for (int i = 0; i < 4; i++) begin
            do_req(1'b0, a[i], 8'h00);
            chk(lat, 18);
            chk(q, d[i]);
        end
        step();
        chk(respValid, 0);
        do_req(1'b0, 11'h123, 8'h00);
        chk(q, 8'h23 ^ 8'ha5);
        $display("test write read done");
    endtask
    // supply drops in mid-write, then returns with a weak battery
    task automatic t_pfail();
        wait_ready();
        reqValid = 1'b1;
        reqWrite = 1'b1;
        reqAddr = 11'h020;
        reqData = 8'h99;
        step();
        reqValid = 1'b0;
        repeat (5) step();
        powerOk = 1'b0;
        lat = 0;
        while ((sramChipSelN & sramWriteN) !== 1'b1) begin
            step();
            lat++;
            guard(lat > 8);
        end
        chk(lat <= 4, 1);
        step();
        chk({dqOe, reqReady}, 2'b00);
        repeat (4) step();
        batWeak = 1'b1;
        powerOk = 1'b1;
        do_req(1'b0, 11'h01f, 8'h00);
        chk(q, 8'h1f ^ 8'ha5);
        do_req(1'b0, 11'h021, 8'h00);
        chk(q, 8'h21 ^ 8'ha5);
        do_req(1'b0, 11'h7ff, 8'h00);
        chk(q, 8'hff);
        $display("test power fail done");
    endtask
    task automatic t_batlow();
        chk(batLow, 1);
        do_req(1'b1, 11'h040, 8'h77);
        do_req(1'b0, 11'h040, 8'h00);
        chk(q, 8'h40 ^ 8'ha5);
        chk(batLow, 0);
        do_req(1'b1, 11'h040, 8'h77);
        do_req(1'b0, 11'h040, 8'h00);
        chk(q, 8'h77);
        $display("test battery low done");
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_reset();
        t_rw();
        t_pfail();
        t_batlow();
        tally_and_finish();
    end
endmodule
`default_nettype wire
